// [rsseq_far_side.sv]
`timescale 1ns/1ps
// ==========================================================
// board reset source and pci bus host, pins change after pclk edges
module rsseq_far_side (
   // clock
   input wire logic pclk,
   // bench commands
   input wire logic reset_cmd,
   input wire logic request_cmd,
   input wire logic dma_cmd,
   input wire logic pci_rst_cmd,
   // pins toward the block
   output logic input_reset_n = 1'b1,
   output logic pci_rst_in_n = 1'b1,
   output logic pci_request = 1'b0,
   output logic pci_activity = 1'b0,
   output logic dma_activity = 1'b0
);
   // registered pin drive; a request or dma burst shows as bus activity
   always @(posedge pclk) begin
      input_reset_n <= !reset_cmd;
      pci_rst_in_n <= !pci_rst_cmd;
      pci_request <= request_cmd;
      pci_activity <= request_cmd | dma_cmd;
      dma_activity <= dma_cmd;
   end
endmodule : rsseq_far_side

// [rsseq_mode_if.sv]
`timescale 1ns/1ps
// ==========================================================
// strapped bus mode, from the strap capture to the sequencer
interface rsseq_mode_if;
   logic strap_valid;
   logic host_mode;
   logic satellite_mode;
   modport src (output strap_valid, output host_mode, output satellite_mode);
   modport dst (input strap_valid, input host_mode, input satellite_mode);
endinterface : rsseq_mode_if

// [rsseq_pkg.sv]
// ==========================================================
// shared constants for the reset and standby sequencer
package rsseq_pkg;
   // register byte offsets
   localparam logic [7:0] REG_CONTROL = 8'h00;
   localparam logic [7:0] REG_STANDBY = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   // control word fields
   localparam int CTL_SOFT_RESET = 0;
   localparam int CTL_SAT_RESET_EN = 1;
   localparam int CTL_SELF_REFRESH = 13;
   // standby register field
   localparam int STB_REQUEST = 0;
   // status word fields
   localparam int STS_RESET_ANY = 0;
   localparam int STS_RESET_EXCLUDING_WATCHDOG = 1;
   localparam int STS_CLOCKS_EN = 2;
   localparam int STS_HOST = 3;
   localparam int STS_SATELLITE = 4;
   localparam int STS_STANDBY = 5;
   localparam int STS_SELF_REFRESH = 6;
   localparam int STS_RATIO_LSB = 8;
   localparam int STS_STATE_LSB = 12;
   // values after reset
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
   localparam logic [2:0] RATIO_RESET = 3'h6;
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int SR_MAX_NS = 2000;
   localparam int SR_MAX_CYCLES = SR_MAX_NS / CLK_PERIOD_NS;
   // clock ratio select codes and ratios
   localparam logic [1:0] RATIO_SEL_3 = 2'h1;
   localparam logic [1:0] RATIO_SEL_4 = 2'h2;
   localparam logic [1:0] RATIO_SEL_5 = 2'h3;
   localparam logic [1:0] RATIO_SEL_6 = 2'h0;
   localparam logic [2:0] RATIO_3 = 3'h3;
   localparam logic [2:0] RATIO_4 = 3'h4;
   localparam logic [2:0] RATIO_5 = 3'h5;
   localparam logic [2:0] RATIO_6 = 3'h6;
   // reset sequencer states
   typedef enum logic [3:0] {
      idle_state, error_wait_state,
      turn_on_first, turn_on_second, turn_on_third, turn_on_fourth,
      reset_hold_first, reset_hold_second, reset_hold_third, reset_hold_fourth,
      turn_off_first, turn_off_second, turn_off_third, turn_off_fourth
   } rsseq_state_t;
endpackage : rsseq_pkg

// [rsseq_self_refresh.sv]
`timescale 1ns/1ps
// ==========================================================
// brings the drams into self-refresh within a bounded time
module rsseq_self_refresh #(
   parameter int LIMIT = rsseq_pkg::SR_MAX_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // control
   input wire logic request,
   input wire logic dram_quiet,
   // status
   output logic active
);
   logic [6:0] wait_count;

   // wait for a quiet controller but never past the limit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_count <= 7'h00;
         active <= 1'b0;
      end else if (ce) begin
         if (!request) begin
            wait_count <= 7'h00;
            active <= 1'b0;
         end else if (!active) begin
            wait_count <= wait_count + 7'h01;
            if (dram_quiet || (wait_count >= 7'(LIMIT - 2))) begin
               active <= 1'b1;
            end
         end
      end
   end
endmodule : rsseq_self_refresh

// [rsseq_strap_capture.sv]
`timescale 1ns/1ps
// ==========================================================
// samples the mode straps once after reset release
module rsseq_strap_capture (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // straps
   input wire logic bypass_strap,
   input wire logic ext_clk_b,
   // mode out
   rsseq_mode_if.src mode
);
   // first enabled edge after release latches the straps, then they hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode.strap_valid <= 1'b0;
         mode.host_mode <= 1'b0;
         mode.satellite_mode <= 1'b0;
      end else if (ce && !mode.strap_valid) begin
         mode.strap_valid <= 1'b1;
         mode.satellite_mode <= bypass_strap && ext_clk_b;
         mode.host_mode <= !(bypass_strap && ext_clk_b);
      end
   end
endmodule : rsseq_strap_capture

// [rsseq_top.sv]
`timescale 1ns/1ps
// Behaviour
// - host mode: external reset drives pci reset
// - satellite: pci reset is input, enable-gated
// - reset lines load fixed state, rams kept
// - general reset: pin, software, satellite pci reset
// - general reset spares clock, reset, test logic
// - scan shift masks external reset pin
// - watchdog on trap-disabled error, after memory idle
// - machine on pci clock; request forces first hold
// - idle until error or reset request
// - error waits for holdoff release, then sequences
// - reset lines asserted; nonwd only for request
// - clocks gated in turn-on, turn-off states
// - reset lines fall only while clocks gated
// - bypass and clock b high: satellite mode
// - bypass high, clock b low: host mode
// - ratio select picks three to six
// - unneeded cache ram powered down that cycle
// - standby after idle and quiet pci bus
// - standby host parks grant on itself
// - request, dma, interrupt or counter clears standby bit, wakes
// - self-refresh entered within two microseconds
module rsseq_top #(
   parameter int ADDR_W = 8,
   parameter int NUM_RAMS = 2,
   parameter int SR_LIMIT = rsseq_pkg::SR_MAX_CYCLES
) (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // reset pins
   input wire logic input_reset_n,
   input wire logic scan_shift,
   input wire logic pci_rst_in_n,
   output logic pci_rst_out_n,
   output logic pci_rst_oe,
   // clock straps and pins
   input wire logic bypass_strap,
   input wire logic external_clock_a,
   input wire logic external_clock_b,
   input wire logic [1:0] clock_ratio_select,
   output logic core_input_clock,
   output logic [2:0] core_ratio,
   output logic pci_clk_oe,
   // integer unit and memory
   input wire logic trap_into_error,
   input wire logic trap_enable_flag,
   input wire logic memory_reset_holdoff,
   // internal reset lines and clock gate
   output logic reset_any,
   output logic reset_excluding_watchdog,
   output logic clocks_enable,
   // cache power
   input wire logic [NUM_RAMS-1:0] cache_access_needed,
   output logic [NUM_RAMS-1:0] cache_powerdown,
   // standby
   input wire logic internal_busy,
   input wire logic pci_activity,
   input wire logic pci_request,
   input wire logic dma_activity,
   input wire logic interrupt_activity,
   input wire logic counter_interrupt,
   output logic clocks_stopped,
   output logic pci_grant_park,
   // dram self-refresh
   input wire logic dram_quiet,
   output logic dram_self_refresh
);
   // ==========================================================
   // declarations
   rsseq_pkg::rsseq_state_t state;
   rsseq_pkg::rsseq_state_t next_state;
   rsseq_mode_if mode_bus ();
   logic soft_reset;
   logic sat_reset_enable;
   logic self_refresh_request;
   logic standby_request;
   logic from_request;
   logic next_from_request;
   logic ext_reset_request;
   logic sat_reset_request;
   logic core_reset_request;
   logic integer_unit_error;
   logic wake;
   logic next_standby;
   logic setup_phase;
   logic access_phase;
   logic hit_control;
   logic hit_standby;
   logic hit_status;
   logic [31:0] read_value;

   // ==========================================================
   // submodules
   rsseq_strap_capture u_strap (
      .pclk (pclk),
      .presetn (presetn),
      .ce (ce),
      .bypass_strap (bypass_strap),
      .ext_clk_b (external_clock_b),
      .mode (mode_bus.src)
   );

   rsseq_self_refresh #(.LIMIT(SR_LIMIT)) u_sr (
      .pclk (pclk),
      .presetn (presetn),
      .ce (ce),
      .request (self_refresh_request),
      .dram_quiet (dram_quiet),
      .active (dram_self_refresh)
   );

   // ==========================================================
   // apb decode; zero wait states, unmapped address errors
   assign setup_phase = psel && !penable;
   assign access_phase = psel && penable;
   assign hit_control = (paddr == ADDR_W'(rsseq_pkg::REG_CONTROL));
   assign hit_standby = (paddr == ADDR_W'(rsseq_pkg::REG_STANDBY));
   assign hit_status = (paddr == ADDR_W'(rsseq_pkg::REG_STATUS));
   assign pready = 1'b1;
   assign pslverr = access_phase && !(hit_control || hit_standby || hit_status);

   // read mux
   always_comb begin
      read_value = 32'h0000_0000;
      if (hit_control) begin
         read_value[rsseq_pkg::CTL_SAT_RESET_EN] = sat_reset_enable;
         read_value[rsseq_pkg::CTL_SELF_REFRESH] = self_refresh_request;
      end else if (hit_standby) begin
         read_value[rsseq_pkg::STB_REQUEST] = standby_request;
      end else if (hit_status) begin
         read_value[rsseq_pkg::STS_RESET_ANY] = reset_any;
         read_value[rsseq_pkg::STS_RESET_EXCLUDING_WATCHDOG] = reset_excluding_watchdog;
         read_value[rsseq_pkg::STS_CLOCKS_EN] = clocks_enable;
         read_value[rsseq_pkg::STS_HOST] = mode_bus.host_mode;
         read_value[rsseq_pkg::STS_SATELLITE] = mode_bus.satellite_mode;
         read_value[rsseq_pkg::STS_STANDBY] = clocks_stopped;
         read_value[rsseq_pkg::STS_SELF_REFRESH] = dram_self_refresh;
         read_value[rsseq_pkg::STS_RATIO_LSB +: 3] = core_ratio;
         read_value[rsseq_pkg::STS_STATE_LSB +: 4] = state;
      end
   end

   // read data captured in the setup cycle, presented in the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (ce && setup_phase) begin
         prdata <= read_value;
      end
   end

   // control word; presetn clears it, general reset does not; the soft reset bit clears itself the next enabled cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_reset <= rsseq_pkg::CONTROL_RESET[rsseq_pkg::CTL_SOFT_RESET];
         sat_reset_enable <= rsseq_pkg::CONTROL_RESET[rsseq_pkg::CTL_SAT_RESET_EN];
         self_refresh_request <= rsseq_pkg::CONTROL_RESET[rsseq_pkg::CTL_SELF_REFRESH];
      end else if (ce) begin
         soft_reset <= 1'b0;
         if (access_phase && pwrite && hit_control) begin
            soft_reset <= pwdata[rsseq_pkg::CTL_SOFT_RESET];
            sat_reset_enable <= pwdata[rsseq_pkg::CTL_SAT_RESET_EN];
            self_refresh_request <= pwdata[rsseq_pkg::CTL_SELF_REFRESH];
         end
      end
   end

   // ==========================================================
   // reset causes
   assign ext_reset_request = !input_reset_n && !scan_shift;
   assign sat_reset_request = mode_bus.satellite_mode && sat_reset_enable && !pci_rst_in_n;
   assign core_reset_request = ext_reset_request || soft_reset || sat_reset_request;
   assign integer_unit_error = trap_into_error && !trap_enable_flag;

   // pci reset pin; driven only in host mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pci_rst_out_n <= 1'b1;
         pci_rst_oe <= 1'b0;
      end else if (ce) begin
         pci_rst_out_n <= !(mode_bus.host_mode && ext_reset_request);
         pci_rst_oe <= mode_bus.host_mode;
      end
   end

   // ==========================================================
   // reset sequencer next state
   always_comb begin
      next_state = state;
      next_from_request = from_request;
      if (core_reset_request) begin
         next_state = rsseq_pkg::reset_hold_first;
         next_from_request = 1'b1;
      end else begin
         unique case (state)
            rsseq_pkg::idle_state: begin
               if (integer_unit_error) begin
                  next_state = rsseq_pkg::error_wait_state;
                  next_from_request = 1'b0;
               end
            end
            rsseq_pkg::error_wait_state: begin
               if (!memory_reset_holdoff) begin
                  next_state = rsseq_pkg::turn_on_first;
               end
            end
            rsseq_pkg::turn_on_first: next_state = rsseq_pkg::turn_on_second;
            rsseq_pkg::turn_on_second: next_state = rsseq_pkg::turn_on_third;
            rsseq_pkg::turn_on_third: next_state = rsseq_pkg::turn_on_fourth;
            rsseq_pkg::turn_on_fourth: next_state = rsseq_pkg::reset_hold_first;
            rsseq_pkg::reset_hold_first: next_state = rsseq_pkg::reset_hold_second;
            rsseq_pkg::reset_hold_second: next_state = rsseq_pkg::reset_hold_third;
            rsseq_pkg::reset_hold_third: next_state = rsseq_pkg::reset_hold_fourth;
            rsseq_pkg::reset_hold_fourth: next_state = rsseq_pkg::turn_off_first;
            rsseq_pkg::turn_off_first: next_state = rsseq_pkg::turn_off_second;
            rsseq_pkg::turn_off_second: next_state = rsseq_pkg::turn_off_third;
            rsseq_pkg::turn_off_third: next_state = rsseq_pkg::turn_off_fourth;
            rsseq_pkg::turn_off_fourth: next_state = rsseq_pkg::idle_state;
            default: next_state = rsseq_pkg::idle_state;
         endcase
      end
   end

   // state register on the pci clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= rsseq_pkg::idle_state;
         from_request <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         from_request <= next_from_request;
      end
   end

   // reset lines and clock gate follow the state, registered together
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_any <= 1'b0;
         reset_excluding_watchdog <= 1'b0;
         clocks_enable <= 1'b1;
      end else if (ce) begin
         reset_any <= next_state inside {rsseq_pkg::turn_on_second, rsseq_pkg::turn_on_third,
            rsseq_pkg::turn_on_fourth, rsseq_pkg::reset_hold_first, rsseq_pkg::reset_hold_second,
            rsseq_pkg::reset_hold_third, rsseq_pkg::reset_hold_fourth,
            rsseq_pkg::turn_off_first};
         reset_excluding_watchdog <= next_from_request && (next_state inside {rsseq_pkg::turn_on_second,
            rsseq_pkg::turn_on_third, rsseq_pkg::turn_on_fourth, rsseq_pkg::reset_hold_first,
            rsseq_pkg::reset_hold_second, rsseq_pkg::reset_hold_third, rsseq_pkg::reset_hold_fourth,
            rsseq_pkg::turn_off_first});
         clocks_enable <= !(next_state inside {rsseq_pkg::turn_on_first, rsseq_pkg::turn_on_second,
            rsseq_pkg::turn_on_third, rsseq_pkg::turn_on_fourth, rsseq_pkg::turn_off_first,
            rsseq_pkg::turn_off_second, rsseq_pkg::turn_off_third,
            rsseq_pkg::turn_off_fourth});
      end
   end

   // ==========================================================
   // clock source and ratio
   assign core_input_clock = bypass_strap ? external_clock_a : (external_clock_a ^ external_clock_b);
   assign pci_clk_oe = mode_bus.host_mode;

   // ratio decode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_ratio <= rsseq_pkg::RATIO_RESET;
      end else if (ce) begin
         unique case (clock_ratio_select)
            rsseq_pkg::RATIO_SEL_3: core_ratio <= rsseq_pkg::RATIO_3;
            rsseq_pkg::RATIO_SEL_4: core_ratio <= rsseq_pkg::RATIO_4;
            rsseq_pkg::RATIO_SEL_5: core_ratio <= rsseq_pkg::RATIO_5;
            rsseq_pkg::RATIO_SEL_6: core_ratio <= rsseq_pkg::RATIO_6;
         endcase
      end
   end

   // per-ram powerdown for the current cycle
   generate
      for (genvar i = 0; i < NUM_RAMS; i++) begin : g_ram
         assign cache_powerdown[i] = !cache_access_needed[i];
      end
   endgenerate

   // ==========================================================
   // standby
   assign wake = pci_request || dma_activity || interrupt_activity || counter_interrupt;
   assign next_standby = standby_request && !wake && (clocks_stopped || (!internal_busy && !pci_activity));

   // standby bit; a wake in the write cycle beats the set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         standby_request <= 1'b0;
      end else if (ce) begin
         if (wake) begin
            standby_request <= 1'b0;
         end else if (access_phase && pwrite && hit_standby) begin
            standby_request <= pwdata[rsseq_pkg::STB_REQUEST];
         end
      end
   end

   // clocks stop once work is done and the bus is quiet
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clocks_stopped <= 1'b0;
         pci_grant_park <= 1'b0;
      end else if (ce) begin
         clocks_stopped <= next_standby;
         pci_grant_park <= next_standby && mode_bus.host_mode;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn || !ce);

   property p_pci_rst_host;
      mode_bus.host_mode && ext_reset_request |=> !pci_rst_out_n && pci_rst_oe;
   endproperty
   a_pci_rst_host: assert property (p_pci_rst_host) else $error("pci reset not driven in host mode");

   property p_sat_no_drive;
      mode_bus.satellite_mode |-> !pci_rst_oe;
   endproperty
   a_sat_no_drive: assert property (p_sat_no_drive) else $error("pci reset driven in satellite mode");

   property p_request_forces;
      core_reset_request |=> state == rsseq_pkg::reset_hold_first;
   endproperty
   a_request_forces: assert property (p_request_forces) else $error("request did not force hold state");

   property p_idle_stays;
      state == rsseq_pkg::idle_state && !integer_unit_error && !core_reset_request |=> $stable(state);
   endproperty
   a_idle_stays: assert property (p_idle_stays) else $error("idle left without cause");

   property p_error_wait;
      state == rsseq_pkg::error_wait_state && !core_reset_request |=>
         state == (memory_reset_holdoff ? rsseq_pkg::error_wait_state : rsseq_pkg::turn_on_first);
   endproperty
   a_error_wait: assert property (p_error_wait) else $error("error wait exit wrong");

   property p_reset_lines;
      (state inside {rsseq_pkg::reset_hold_first, rsseq_pkg::reset_hold_fourth, rsseq_pkg::turn_off_first}
         |-> reset_any) and (reset_excluding_watchdog |-> reset_any && from_request);
   endproperty
   a_reset_lines: assert property (p_reset_lines) else $error("reset lines inconsistent with state");

   property p_watchdog_seq;
      state == rsseq_pkg::turn_on_first && !core_reset_request |=>
         reset_any && !reset_excluding_watchdog && !clocks_enable;
   endproperty
   a_watchdog_seq: assert property (p_watchdog_seq) else $error("watchdog asserts wrong lines");

   property p_gated;
      state inside {rsseq_pkg::turn_on_first, rsseq_pkg::turn_on_fourth, rsseq_pkg::turn_off_second,
         rsseq_pkg::turn_off_fourth} |-> !clocks_enable;
   endproperty
   a_gated: assert property (p_gated) else $error("clocks not gated in transition");

   property p_fall_gated;
      $fell(reset_any) |-> !clocks_enable;
   endproperty
   a_fall_gated: assert property (p_fall_gated) else $error("reset released with clocks running");

   property p_ratio;
      clock_ratio_select == rsseq_pkg::RATIO_SEL_6 |=> core_ratio == rsseq_pkg::RATIO_6;
   endproperty
   a_ratio: assert property (p_ratio) else $error("ratio decode wrong");

   property p_wake;
      wake |=> !standby_request && !clocks_stopped && !pci_grant_park;
   endproperty
   a_wake: assert property (p_wake) else $error("standby not cleared by activity");

   property p_park;
      clocks_stopped && mode_bus.host_mode |-> pci_grant_park;
   endproperty
   a_park: assert property (p_park) else $error("grant not parked in standby");

   property p_self_refresh;
      $rose(self_refresh_request) |-> ##[1:80] (dram_self_refresh || !self_refresh_request);
   endproperty
   a_self_refresh: assert property (p_self_refresh) else $error("self-refresh too late");

   c_watchdog: cover property (state == rsseq_pkg::error_wait_state ##1 state == rsseq_pkg::turn_on_first);
   c_full_seq: cover property (state == rsseq_pkg::turn_off_fourth ##1 state == rsseq_pkg::idle_state);
   c_standby: cover property ($rose(clocks_stopped));
   c_refresh: cover property ($rose(dram_self_refresh));
endmodule : rsseq_top

// [testbench.sv]
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the reset and standby sequencer
module testbench;
   localparam int SR_LIM = 4;
   logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, pci_rst_out_n, pci_rst_oe, core_input_clock, pci_clk_oe, reset_any;
   logic scan_shift = 1'b0, bypass_strap = 1'b0, external_clock_a = 1'b0, external_clock_b = 1'b0;
   logic [1:0] clock_ratio_select = 2'h0, cache_access_needed = 2'h0, cache_powerdown;
   logic [2:0] core_ratio;
   logic trap_into_error = 1'b0, trap_enable_flag = 1'b0, memory_reset_holdoff = 1'b0, dram_quiet = 1'b0;
   logic reset_excluding_watchdog, clocks_enable, clocks_stopped, pci_grant_park, dram_self_refresh;
   logic internal_busy = 1'b0, interrupt_activity = 1'b0, counter_interrupt = 1'b0;
   logic input_reset_n, pci_rst_in_n, pci_request, pci_activity, dma_activity;
   logic reset_cmd = 1'b0, request_cmd = 1'b0, dma_cmd = 1'b0, pci_rst_cmd = 1'b0;
   int bad_count = 0, checks_done = 0, n, k;
   // design and far side
   rsseq_top #(.SR_LIMIT(SR_LIM)) i_dut (.*);
   rsseq_far_side i_host (.*);
   // clock
   initial forever #12.5 pclk = ~pclk;
   // closing report
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   // a hang counts as a mismatch
   task automatic timeout;
      bad_count++;
      wrap_up();
   endtask : timeout
   // compare seen against expected
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // apb transfer: setup, then access until pready at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 50) timeout();
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   // bounded wait on a level at falling edges
   task automatic wait_lv(ref logic s, input logic v);
      for (n = 0; n < 200 && s !== v; n++) @(negedge pclk);
      if (n == 200) timeout();
   endtask : wait_lv
   // {reset_any, nonwd, clocks_enable} by position, hold1 = 0, turn-on first = -4
   function automatic logic [2:0] exp_lines(input int p, input logic nw);
      if (p < -3) return 3'h0;
      if (p < 0) return 3'h4;
      if (p < 5) return {1'b1, nw, p < 4};
      return (p < 8) ? 3'h0 : 3'h1;
   endfunction : exp_lines
   // walk the sequence one state per clock
   task automatic run_seq(input int first, input logic nw);
      for (k = first; k <= 8; k++) begin
         chk("lines", 32'({reset_any, reset_excluding_watchdog, clocks_enable}), 32'(exp_lines(k, nw)));
         @(negedge pclk);
      end
   endtask : run_seq
   // main sequence
   initial begin
      void'($urandom(83));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(negedge pclk);
      chk("pins", 32'({pci_rst_out_n, pci_rst_oe, pci_clk_oe, reset_any, clocks_enable}), 32'h0000_001D);
      for (k = 0; k < 24; k++) begin
         @(posedge pclk);
         {cache_access_needed, external_clock_a, external_clock_b, clock_ratio_select} <= 6'($urandom);
         repeat (3) @(negedge pclk);
         chk("pdown", 32'(cache_powerdown), 32'({~cache_access_needed}));
         chk("cclk", 32'(core_input_clock), 32'(external_clock_a ^ external_clock_b));
         chk("ratio", 32'(core_ratio), (clock_ratio_select == 2'h0) ? 32'h6 : 32'(clock_ratio_select) + 2);
      end
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped", {rd[30:0], err}, 32'h0000_0001);
      apb(1'b1, rsseq_pkg::REG_CONTROL, 32'h0000_0001);
      wait_lv(reset_any, 1'b1);
      run_seq(0, 1'b1);
      apb(1'b0, rsseq_pkg::REG_STATUS, 32'h0000_0000);
      chk("status", 32'({rd[15:12], rd[5:0]}), 32'h0000_000C);
      @(posedge pclk);
      {scan_shift, reset_cmd} <= 2'b11;
      repeat (8) @(negedge pclk);
      chk("masked", 32'({reset_any, pci_rst_out_n}), 32'h1);
      @(posedge pclk);
      scan_shift <= 1'b0;
      wait_lv(reset_any, 1'b1);
      repeat (6) @(negedge pclk);
      chk("held", 32'({reset_any, clocks_enable, pci_rst_out_n}), 32'h6);
      @(posedge pclk);
      reset_cmd <= 1'b0;
      wait_lv(clocks_enable, 1'b0);
      run_seq(4, 1'b1);
      @(posedge pclk);
      {trap_into_error, trap_enable_flag, memory_reset_holdoff} <= 3'b111;
      @(posedge pclk);
      trap_enable_flag <= 1'b0;
      @(posedge pclk);
      trap_into_error <= 1'b0;
      repeat (6) @(negedge pclk);
      chk("errwait", 32'({reset_any, clocks_enable}), 32'h1);
      apb(1'b0, rsseq_pkg::REG_STATUS, 32'h0000_0000);
      chk("errstate", 32'(rd[15:12]), 32'h1);
      {ce, memory_reset_holdoff} <= 2'b00;
      repeat (4) @(negedge pclk);
      chk("frozen", 32'(clocks_enable), 32'h1);
      @(posedge pclk);
      ce <= 1'b1;
      wait_lv(clocks_enable, 1'b0);
      run_seq(-4, 1'b0);
      for (int w = 0; w < 4; w++) begin
         @(posedge pclk);
         internal_busy <= 1'b1;
         apb(1'b1, rsseq_pkg::REG_STANDBY, 32'h0000_0001);
         repeat (4) @(negedge pclk);
         chk("busy", 32'(clocks_stopped), 32'h0);
         @(posedge pclk);
         internal_busy <= 1'b0;
         wait_lv(clocks_stopped, 1'b1);
         chk("park", 32'(pci_grant_park), 32'h1);
         @(posedge pclk);
         {counter_interrupt, interrupt_activity, dma_cmd, request_cmd} <= 4'h1 << w;
         repeat (4) @(negedge pclk);
         @(posedge pclk);
         {counter_interrupt, interrupt_activity, dma_cmd, request_cmd} <= 4'h0;
         apb(1'b0, rsseq_pkg::REG_STANDBY, 32'h0000_0000);
         chk("wake", {rd[31:1], rd[0] | clocks_stopped}, 32'h0);
      end
      apb(1'b1, rsseq_pkg::REG_CONTROL, 32'h0000_2000);
      for (n = 0; n < 20 && dram_self_refresh !== 1'b1; n++) @(negedge pclk);
      chk("sr_time", 32'(n <= SR_LIM + 1), 32'h1);
      // second reset with satellite straps; pci reset pin held low from the start
      @(posedge pclk);
      {presetn, bypass_strap, external_clock_b, pci_rst_cmd} <= 4'b0111;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(negedge pclk);
      chk("sat", 32'({reset_any, pci_rst_oe, pci_clk_oe, core_input_clock ^ external_clock_a}), 32'h0);
      apb(1'b1, rsseq_pkg::REG_CONTROL, 32'h0000_0002);
      wait_lv(reset_any, 1'b1);
      chk("satrst", 32'(reset_excluding_watchdog), 32'h1);
      wrap_up();
   end
   // overall limit
   initial begin
      #2_500_000;
      timeout();
   end
endmodule : testbench
